// [verification/cal_engine_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Calibration engine stand-in
// ----
module cal_engine_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       adjust_start,
  input  wire logic       cfg_ok,
  input  wire logic [2:0] cfg_sensor,
  input  wire logic [7:0] cfg_value,
  input  wire logic [7:0] cfg_delay,
  output logic            adjust_done,
  output logic            adjust_ok,
  output logic [2:0]      fail_sensor,
  output logic [7:0]      adjust_value
);
  logic       busy;
  logic [7:0] wait_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      wait_cnt <= 8'h0;
    end else if (adjust_start) begin
      busy <= 1'b1;
      wait_cnt <= cfg_delay;
    end else if (busy) begin
      busy <= wait_cnt != 8'h0;
      wait_cnt <= wait_cnt - 8'h1;
    end
  end
  // Qualifiers are inverted outside the done cycle so late sampling shows
  assign adjust_done = busy && wait_cnt == 8'h0;
  assign adjust_ok = adjust_done ? cfg_ok : ~cfg_ok;
  assign fail_sensor = adjust_done ? cfg_sensor : ~cfg_sensor;
  assign adjust_value = adjust_done ? cfg_value : ~cfg_value;
endmodule
`default_nettype wire

// [verification/service_mode_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module sm_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       start_button,
  input wire logic [3:0] mode_select_switch,
  input wire logic       punch_fitted,
  input wire logic       trimmer_fitted,
  input wire logic       adjust_done,
  input wire logic       adjust_ok,
  input wire logic [7:0] adjust_value,
  input wire logic       adjust_start,
  input wire logic [1:0] adjust_kind,
  input wire logic       nvm_write,
  input wire logic [7:0] nvm_data,
  input wire logic       primary_indicator,
  input wire logic       secondary_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Raw press length; debounce delays both edges alike
  logic [31:0] held;
  logic [31:0] last_held;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held <= 32'h0;
      last_held <= 32'h0;
    end else begin
      held <= start_button ? held + 32'h1 : 32'h0;
      last_held <= (!start_button && held != 32'h0) ? held : last_held;
    end
  end
  a_long_press: assert property (
    adjust_start |-> last_held >= 32'(1999 * TICK_CYCLES)) else $error("start after short press");
  a_start_released: assert property (
    adjust_start |-> !start_button && !$past(start_button, 2)) else $error("start while held");
  a_kind_decode: assert property (
    adjust_start |-> (mode_select_switch == 4'h1 && adjust_kind == 2'h0)
      || (mode_select_switch == 4'h2 && adjust_kind == 2'h1)
      || (mode_select_switch == 4'h3 && adjust_kind == 2'h2)) else $error("bad kind");
  a_unit_present: assert property (
    adjust_start |-> (mode_select_switch == 4'h3 ? trimmer_fitted : punch_fitted))
    else $error("start without unit");
  a_lit_start: assert property (
    adjust_start |=> primary_indicator && secondary_indicator) else $error("not lit");
  a_lit_hold: assert property (
    secondary_indicator && !adjust_done && !$past(adjust_done)
      |=> primary_indicator && secondary_indicator) else $error("lit dropped");
  a_both_lit: assert property (
    secondary_indicator |-> primary_indicator) else $error("secondary alone");
  a_nvm_store: assert property (
    adjust_done && adjust_ok && secondary_indicator
      |=> nvm_write && nvm_data == $past(adjust_value)) else $error("no store");
  a_nvm_cause: assert property (
    nvm_write |-> $past(adjust_done) && $past(adjust_ok)) else $error("stray store");
  cover property (adjust_start);
  cover property (nvm_write);
  cover property (adjust_done && !adjust_ok);
endmodule
bind service_mode_sensor_adjust_ui sm_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk, .resetn, .start_button, .mode_select_switch, .punch_fitted, .trimmer_fitted,
  .adjust_done, .adjust_ok, .adjust_value, .adjust_start, .adjust_kind, .nvm_write,
  .nvm_data, .primary_indicator, .secondary_indicator);
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int T = 2;
  logic clk = 1'b0, resetn = 1'b0, start_button = 1'b0, cancel_button = 1'b0;
  logic punch_fitted = 1'b1, trimmer_fitted = 1'b1, cfg_ok = 1'b1;
  logic wr_en = 1'b0, rd_en = 1'b0, irq, adjust_start, nvm_write, adjust_done, adjust_ok;
  logic primary_indicator, secondary_indicator;
  logic [3:0] mode_select_switch = 4'h0, addr = 4'h0;
  logic [31:0] wr_data = 32'h0, rd_data;
  logic [2:0] fail_sensor, cfg_sensor = 3'h1;
  logic [7:0] adjust_value, nvm_data, nvm_seen, cfg_value = 8'h0, cfg_delay = 8'h2;
  logic [1:0] adjust_kind;
  int n_fail = 0, samples_checked = 0, n_nvm = 0;
  initial forever #4 clk = ~clk;
  service_mode_sensor_adjust_ui #(.TICK_CYCLES(T)) uut (.clk, .resetn, .start_button,
    .cancel_button, .mode_select_switch, .punch_fitted, .trimmer_fitted, .adjust_done,
    .adjust_ok, .fail_sensor, .adjust_value, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .irq, .adjust_start, .adjust_kind, .nvm_write, .nvm_data, .primary_indicator,
    .secondary_indicator);
  cal_engine_model cal (.clk, .resetn, .adjust_start, .cfg_ok, .cfg_sensor, .cfg_value,
    .cfg_delay, .adjust_done, .adjust_ok, .fail_sensor, .adjust_value);
  always @(posedge clk) begin
    if (nvm_write === 1'b1) begin
      nvm_seen <= nvm_data;
      n_nvm <= n_nvm + 1;
    end
  end
  function automatic logic [1:0] kind_of(input logic [3:0] m);
    return m == 4'h2 ? 2'h1 : (m == 4'h3 ? 2'h2 : 2'h0);
  endfunction
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= wd;
    wr_en <= w;
    rd_en <= !w;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic setup(input logic [3:0] m, input bit ok, input bit p, input bit t);
    @(posedge clk);
    mode_select_switch <= m;
    cfg_ok <= ok;
    punch_fitted <= p;
    trimmer_fitted <= t;
    cfg_value <= 8'($urandom);
    cfg_sensor <= 3'($urandom_range(5, 1));
    cfg_delay <= 8'($urandom_range(60, 2));
  endtask
  // Long press, release, then look for the start pulse
  task automatic press(input int ticks, input bit exp, input string msg);
    bit got;
    got = 1'b0;
    @(posedge clk);
    start_button <= 1'b1;
    repeat (ticks * T) @(posedge clk);
    start_button <= 1'b0;
    for (int i = 0; i < 40 * T && !got; i++) begin
      @(posedge clk);
      #1;
      got = adjust_start === 1'b1;
    end
    chk(got == exp, msg);
  endtask
  task automatic run_adj();
    chk(adjust_kind === kind_of(mode_select_switch), "kind");
    @(posedge clk);
    #1;
    chk(primary_indicator === 1'b1 && secondary_indicator === 1'b1, "lit");
    for (int i = 0; i < 300 && secondary_indicator === 1'b1; i++) @(negedge clk);
    chk(secondary_indicator === 1'b0, "adjust end");
    repeat (3) @(negedge clk);
  endtask
  task automatic cancel();
    @(posedge clk);
    cancel_button <= 1'b1;
    repeat (30 * T) @(posedge clk);
    cancel_button <= 1'b0;
  endtask
  task automatic runs(output int h, output int l);
    h = 0;
    l = 0;
    for (int i = 0; i < 3000 * T && primary_indicator !== 1'b1; i++) @(negedge clk);
    for (; h < 3000 * T && primary_indicator === 1'b1; h++) @(negedge clk);
    for (; l < 3000 * T && primary_indicator !== 1'b1; l++) @(negedge clk);
  endtask
  // First run may be cut by the state change, so the second is judged
  task automatic blink(input int on, input int off, input string msg);
    int h, l;
    runs(h, l);
    runs(h, l);
    chk(h >= (on - 1) * T && h <= (on + 1) * T && l >= (off - 1) * T
        && l <= (off + 1) * T, msg);
  endtask
  initial begin
    #(90000 * 8);
    n_fail++;
    finish_test();
  end
  initial begin
    logic [31:0] d;
    int h, l, n;
    logic [3:0] dis [5];
    dis = '{4'h0, 4'hf, 4'h4, 4'h9, 4'h5};
    void'($urandom(32'h9d221287));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, 4'h2, 32'h0, d);
    chk(d === 32'h0, "unmapped read");
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d[0] === 1'b1, "armed after clean power-up");
    bus(1'b1, 4'h4, 32'h7, d);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(d[2:0] === 3'h7, "mask readback");
    setup(4'h1, 1'b1, 1'b1, 1'b1);
    press(2025, 1'b1, "reg start");
    run_adj();
    chk(nvm_seen === cfg_value && n_nvm == 1, "nvm store");
    bus(1'b0, 4'hc, 32'h0, d);
    chk(d === {24'h000000, cfg_value}, "stored value readback");
    bus(1'b0, 4'h0, 32'h0, d);
    chk(d[0] === 1'b1 && irq === 1'b1, "ok event");
    bus(1'b1, 4'h0, 32'h7, d);
    repeat (2) @(negedge clk);
    chk(irq === 1'b0, "irq clear");
    blink(500, 500, "idle after ok");
    press(1900, 1'b0, "short press");
    setup(dis[$urandom_range(4, 0)], 1'b1, 1'b1, 1'b1);
    press(2025, 1'b0, "disabled code");
    for (int k = 0; k < 2; k++) begin
      setup(4'(k + 2), 1'b1, k == 1, k == 0);
      press(2025, 1'b0, "missing unit");
      blink(100, 100, "fast blink");
      cancel();
      blink(500, 500, "cancel missing");
    end
    setup(4'h3, 1'b0, 1'b1, 1'b1);
    press(2025, 1'b1, "trim start");
    run_adj();
    blink(250, 250, "dust fail");
    cancel();
    blink(500, 500, "cancel fail");
    setup(4'h1, 1'b0, 1'b1, 1'b1);
    press(2025, 1'b1, "reg fail start");
    run_adj();
    n = 0;
    l = 0;
    while (l < 600 * T && n < 8) begin
      runs(h, l);
      n++;
    end
    chk(n == int'(cfg_sensor), "flash count");
    chk(l >= 1249 * T && l <= 1251 * T, "burst gap");
    // Power-up with a function already selected must not reach service mode
    @(posedge clk);
    resetn <= 1'b0;
    mode_select_switch <= 4'h1;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d[0] === 1'b0, "armed after bad power-up");
    press(2025, 1'b0, "start after bad power-up");
    finish_test();
  end
endmodule
`default_nettype wire

// [verilog/service_mode_pkg.sv]
package service_mode_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_held,
    st_adjust,
    st_missing,
    st_fail_reg,
    st_fail_dust
  } state_t;
endpackage

// [verilog/service_mode_regs.svh]
// Behaviour
// - Four-bit selector picks one of sixteen service functions.
// - Start accepted only after a press of at least 2 sec.
// - Adjustment begins when start is released, not while held.
// - Punch adjustment without punch unit: primary blinks 100ms on, 100ms off.
// - Trimmer adjustment without trimmer unit: same 100ms blink.
// - Cancel during missing-unit blink returns to idle 0.5 sec blink.
// - Both indicators steadily on while an adjustment runs.
// - Success writes new value to nonvolatile memory, idle blink returns.
// - Registration failure shows failing sensor as one to five flashes.
// - Flashes 250ms on/off, then 1000ms off gap, repeating.
// - Dust adjustment failure blinks primary 250ms on, 250ms off.
// - Cancel during failure display returns to idle blink.
`ifndef SERVICE_MODE_REGS_SVH
`define SERVICE_MODE_REGS_SVH

`define CLK_HZ          125000000
`define TICK_MS         1
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define LONG_PRESS_MS   2000
`define LONG_PRESS_T    11'(`LONG_PRESS_MS / `TICK_MS)
`define DEBOUNCE_MS     20
`define DEBOUNCE_T      (`DEBOUNCE_MS / `TICK_MS)
`define IDLE_SLOT_T     10'(1000 / `TICK_MS)
`define FAST_SLOT_T     10'(200 / `TICK_MS)
`define FAIL_SLOT_T     10'(500 / `TICK_MS)
`define GAP_SLOTS       3'h2

`define MODE_DISABLE    4'h0
`define MODE_REG        4'h1
`define MODE_PUNCH_DUST 4'h2
`define MODE_TRIM_DUST  4'h3
`define MODE_BLEED      4'h5

`define KIND_REG        2'h0
`define KIND_PUNCH      2'h1
`define KIND_TRIM       2'h2

`define ADDR_STATUS     4'h0
`define ADDR_MASK       4'h4
`define ADDR_INFO       4'h8
`define ADDR_VALUE      4'hc
`define EV_OK_BIT       0
`define EV_FAIL_BIT     1
`define EV_MISS_BIT     2
`define STATUS_RESET    3'h0
`define MASK_RESET      3'h0

`endif

// [verilog/service_mode_sensor_adjust_ui.sv]
`timescale 1ns/1ps
`default_nettype none
`include "service_mode_regs.svh"

// ----------------------------------------
// Push button filter
// ----------------------------------------
module button_filter #(
  parameter int unsigned STABLE = 20
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tick,
  input  wire logic raw,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [5:0] stable_cnt;

  // Level flips only after the raw input disagrees for STABLE ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level      <= 1'b0;
      stable_cnt <= 6'h00;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (raw == level) begin
        stable_cnt <= 6'h00;
      end else if (tick) begin
        if (stable_cnt == 6'(STABLE - 1)) begin
          stable_cnt <= 6'h00;
          level      <= raw;
          rise       <= raw;
          fall       <= !raw;
        end else begin
          stable_cnt <= stable_cnt + 6'h01;
        end
      end
    end
  end
endmodule

// ----------------------------------------
// Service mode controller
// ----------------------------------------
module service_mode_sensor_adjust_ui #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        start_button,
  input  wire logic        cancel_button,
  input  wire logic [3:0]  mode_select_switch,
  input  wire logic        punch_fitted,
  input  wire logic        trimmer_fitted,
  input  wire logic        adjust_done,
  input  wire logic        adjust_ok,
  input  wire logic [2:0]  fail_sensor,
  input  wire logic [7:0]  adjust_value,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  output logic             irq,
  output logic             adjust_start,
  output logic [1:0]       adjust_kind,
  output logic             nvm_write,
  output logic [7:0]       nvm_data,
  output logic             primary_indicator,
  output logic             secondary_indicator
);
  service_mode_pkg::state_t state;

  logic [16:0] tick_cnt;
  logic        tick;
  logic        boot_seen;
  logic        armed;
  logic        start_level;
  logic        start_fall;
  logic        cancel_rise;
  logic [10:0] hold_t;
  logic        is_reg;
  logic        is_punch;
  logic        is_trim;
  logic        is_adjust;
  logic [2:0]  flash_count;
  logic        pat_restart;
  logic [9:0]  slot_t;
  logic [2:0]  slot_no;
  logic [9:0]  slot_len;
  logic [2:0]  slot_total;
  logic [2:0]  lit_slots;
  logic        ev_ok;
  logic        ev_fail;
  logic        ev_miss;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [2:0]  clear_bits;
  logic [7:0]  last_value;

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
      tick     <= 1'b0;
    end
  end

  button_filter #(
    .STABLE (`DEBOUNCE_T)
  ) u_start_filter (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick),
    .raw    (start_button),
    .level  (start_level),
    .rise   (),
    .fall   (start_fall)
  );

  button_filter #(
    .STABLE (`DEBOUNCE_T)
  ) u_cancel_filter (
    .clk    (clk),
    .resetn (resetn),
    .tick   (tick),
    .raw    (cancel_button),
    .level  (),
    .rise   (cancel_rise),
    .fall   ()
  );

  // ----------------------------------------
  // Power-up selector check
  // ----------------------------------------
  // The selector is sampled once after reset release, never under reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_seen <= 1'b0;
      armed     <= 1'b0;
    end else if (!boot_seen) begin
      boot_seen <= 1'b1;
      armed     <= (mode_select_switch == `MODE_DISABLE);
    end
  end

  // ----------------------------------------
  // Function decode
  // ----------------------------------------
  // Codes not listed here, all on included, fall back to disable
  assign is_reg    = (mode_select_switch == `MODE_REG);
  assign is_punch  = (mode_select_switch == `MODE_PUNCH_DUST);
  assign is_trim   = (mode_select_switch == `MODE_TRIM_DUST);
  // Bleedthrough setting is a separate procedure and is not started here
  assign is_adjust = is_reg || is_punch || is_trim;

  // ----------------------------------------
  // Long press timer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_t <= 11'h000;
    end else if (!start_level) begin
      hold_t <= 11'h000;
    end else if (tick && hold_t != `LONG_PRESS_T) begin
      hold_t <= hold_t + 11'h001;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state        <= service_mode_pkg::st_idle;
      adjust_start <= 1'b0;
      adjust_kind  <= `KIND_REG;
      nvm_write    <= 1'b0;
      nvm_data     <= 8'h00;
      flash_count  <= 3'h1;
      pat_restart  <= 1'b0;
      ev_ok        <= 1'b0;
      ev_fail      <= 1'b0;
      ev_miss      <= 1'b0;
    end else begin
      adjust_start <= 1'b0;
      nvm_write    <= 1'b0;
      pat_restart  <= 1'b0;
      ev_ok        <= 1'b0;
      ev_fail      <= 1'b0;
      ev_miss      <= 1'b0;
      unique case (state)
        service_mode_pkg::st_idle: begin
          if (armed && is_adjust && hold_t == `LONG_PRESS_T) begin
            state <= service_mode_pkg::st_held;
          end
        end
        service_mode_pkg::st_held: begin
          // Nothing starts until the button is let go
          if (start_fall) begin
            pat_restart <= 1'b1;
            if (((is_reg || is_punch) && !punch_fitted) || (is_trim && !trimmer_fitted)) begin
              state   <= service_mode_pkg::st_missing;
              ev_miss <= 1'b1;
            end else if (is_adjust) begin
              state        <= service_mode_pkg::st_adjust;
              adjust_start <= 1'b1;
              adjust_kind  <= is_reg ? `KIND_REG :
                              (is_punch ? `KIND_PUNCH : `KIND_TRIM);
            end else begin
              // Selector moved off an adjustment while held
              state <= service_mode_pkg::st_idle;
            end
          end
        end
        service_mode_pkg::st_adjust: begin
          if (adjust_done) begin
            pat_restart <= 1'b1;
            if (adjust_ok) begin
              state     <= service_mode_pkg::st_idle;
              nvm_write <= 1'b1;
              nvm_data  <= adjust_value;
              ev_ok     <= 1'b1;
            end else if (adjust_kind == `KIND_REG) begin
              state   <= service_mode_pkg::st_fail_reg;
              ev_fail <= 1'b1;
              // Out-of-range sensor numbers are clamped to one..five
              flash_count <= (fail_sensor == 3'h0) ? 3'h1 :
                             ((fail_sensor > 3'h5) ? 3'h5 : fail_sensor);
            end else begin
              state   <= service_mode_pkg::st_fail_dust;
              ev_fail <= 1'b1;
            end
          end
        end
        service_mode_pkg::st_missing,
        service_mode_pkg::st_fail_reg,
        service_mode_pkg::st_fail_dust: begin
          if (cancel_rise) begin
            state       <= service_mode_pkg::st_idle;
            pat_restart <= 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Indicator patterns
  // ----------------------------------------
  // Every pattern except the steady adjust display is slots of equal length, lit for the first half of
  // each of the first lit_slots slots
  always_comb begin
    slot_len   = `IDLE_SLOT_T;
    slot_total = 3'h1;
    lit_slots  = 3'h1;
    unique case (state)
      service_mode_pkg::st_missing:   slot_len = `FAST_SLOT_T;
      service_mode_pkg::st_fail_dust: slot_len = `FAIL_SLOT_T;
      service_mode_pkg::st_fail_reg: begin
        // Two dark slots make the 1000ms gap after the burst
        slot_len   = `FAIL_SLOT_T;
        slot_total = flash_count + `GAP_SLOTS;
        lit_slots  = flash_count;
      end
      service_mode_pkg::st_idle, service_mode_pkg::st_held,
      service_mode_pkg::st_adjust: slot_len = `IDLE_SLOT_T;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_t  <= 10'h000;
      slot_no <= 3'h0;
    end else if (pat_restart) begin
      slot_t  <= 10'h000;
      slot_no <= 3'h0;
    end else if (tick) begin
      if (slot_t >= slot_len - 10'h001) begin
        slot_t  <= 10'h000;
        slot_no <= (slot_no >= slot_total - 3'h1) ? 3'h0 : slot_no + 3'h1;
      end else begin
        slot_t <= slot_t + 10'h001;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primary_indicator   <= 1'b0;
      secondary_indicator <= 1'b0;
    end else if (state == service_mode_pkg::st_adjust) begin
      primary_indicator   <= 1'b1;
      secondary_indicator <= 1'b1;
    end else begin
      primary_indicator   <= (slot_no < lit_slots) && (slot_t < (slot_len >> 1));
      secondary_indicator <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register port and interrupt
  // ----------------------------------------
  assign clear_bits = (wr_en && addr == `ADDR_STATUS) ? wr_data[2:0] : 3'h0;
  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= `STATUS_RESET;
    end else begin
      status <= (status & ~clear_bits) | {ev_miss, ev_fail, ev_ok};
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask <= `MASK_RESET;
    end else if (wr_en && addr == `ADDR_MASK) begin
      mask <= wr_data[2:0];
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_value <= 8'h00;
    end else if (nvm_write) begin
      last_value <= nvm_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 32'h00000000;
    end else if (rd_en) begin
      unique case (addr)
        `ADDR_STATUS: rd_data <= {29'h00000000, status};
        `ADDR_MASK:   rd_data <= {29'h00000000, mask};
        `ADDR_INFO:   rd_data <= {19'h00000, 1'b0, flash_count, 1'b0, state,
                                  mode_select_switch, armed};
        `ADDR_VALUE:  rd_data <= {24'h000000, last_value};
        default:      rd_data <= 32'h00000000;
      endcase
    end else begin
      rd_data <= 32'h00000000;
    end
  end
endmodule

`default_nettype wire
